// ### timer_x_pkg.sv
// Constants, register map and bus carriers for the basic timer block
package timer_x_pkg;

  localparam int CNT_W = 8;
  localparam int IDX_W = 10;

  // Register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MODE      = 10'h08b;
  localparam logic [IDX_W-1:0] IDX_PRESCALER = 10'h08c;
  localparam logic [IDX_W-1:0] IDX_TIMER     = 10'h08d;
  localparam logic [IDX_W-1:0] IDX_SOURCE    = 10'h08e;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT  = 10'h090;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK  = 10'h091;

  // Mode register fields
  localparam int MODE_SEL_LOW0  = 0;
  localparam int MODE_SEL_LOW1  = 1;
  localparam int MODE_POLARITY  = 2;
  localparam int MODE_RUN       = 3;
  localparam int MODE_INV_OUT   = 4;
  localparam int MODE_SEL_UPPER = 5;
  localparam int MODE_AUX_EDGE  = 6;
  localparam int MODE_AUX_UNDER = 7;

  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] CNT_RESET    = 8'hff;
  localparam logic [1:0] SOURCE_RESET = 2'h0;
  localparam logic [1:0] IRQ_RESET    = 2'h0;

  // Count source select codes
  localparam logic [1:0] SRC_DIV1 = 2'h0;
  localparam logic [1:0] SRC_DIV8 = 2'h1;
  localparam logic [1:0] SRC_RING = 2'h2;
  localparam logic [1:0] SRC_DIV2 = 2'h3;

  localparam logic [2:0] DIV8_LAST = 3'h7;

  // Interrupt status bits
  localparam int IRQ_BIT_UNDER = 0;
  localparam int IRQ_BIT_EXT   = 1;
  localparam int IRQ_W         = 2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    LOAD_IDLE,
    LOAD_RELOAD,
    LOAD_COUNTER
  } load_phase_e;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } ahb_in_s;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } ahb_out_s;

endpackage : timer_x_pkg

// ### timer_x_basic.sv
// Basic timer mode of an 8-bit prescaled down-counting timer with AHB-Lite registers
`timescale 1ns/1ps

module timer_x_basic (
  // Clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst_n,
  // Register bus
  input  wire timer_x_pkg::ahb_in_s i_ahb,
  output timer_x_pkg::ahb_out_s     o_ahb,
  // Pins
  input  wire logic                 i_ring_osc_clock,
  input  wire logic                 i_ext_interrupt_input,
  // Interrupt
  output logic                      o_irq
);
  import timer_x_pkg::*;

  function automatic logic [IDX_W-1:0] addr_index(input logic [31:0] addr);
    addr_index = addr[IDX_W+1:2];
  endfunction : addr_index

  logic [7:0]          mode;
  logic [1:0]          source_sel;
  logic [CNT_W-1:0]    pre_reload;
  logic [CNT_W-1:0]    pre_cnt;
  logic [CNT_W-1:0]    main_reload;
  logic [CNT_W-1:0]    main_cnt;
  logic [CNT_W-1:0]    pre_hold;
  logic [CNT_W-1:0]    main_hold;
  load_phase_e         pre_phase;
  load_phase_e         main_phase;
  logic [IRQ_W-1:0]    irq_stat;
  logic [IRQ_W-1:0]    irq_mask;
  logic [2:0]          div_cnt;
  logic [1:0]          ring_sync;
  logic                ring_prev;
  logic [1:0]          ext_sync;
  logic                ext_prev;
  logic                dp_write;
  logic [IDX_W-1:0]    dp_index;

  logic                addr_valid;
  logic                rd_take;
  logic                wr_mode;
  logic                wr_pre;
  logic                wr_main;
  logic                basic_mode;
  logic                running;
  logic                src_tick;
  logic                pre_tick;
  logic                pre_under;
  logic                main_under;
  logic                ext_active;
  logic                ext_edge;
  logic                clr_stat;
  logic [CNT_W-1:0]    wdata;
  logic [31:0]         next_rdata;

  // Bus address phase
  assign addr_valid = i_ahb.hsel && i_ahb.hready && (i_ahb.htrans == HTRANS_NONSEQ);
  assign rd_take    = addr_valid && !i_ahb.hwrite;
  assign clr_stat   = rd_take && (addr_index(i_ahb.haddr) == IDX_IRQ_STAT);
  assign wdata      = i_ahb.hwdata[CNT_W-1:0];
  assign wr_mode    = dp_write && (dp_index == IDX_MODE);
  assign wr_pre     = dp_write && (dp_index == IDX_PRESCALER);
  assign wr_main    = dp_write && (dp_index == IDX_TIMER);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dp_write <= 1'b0;
      dp_index <= '0;
    end else begin
      dp_write <= addr_valid && i_ahb.hwrite;
      dp_index <= addr_index(i_ahb.haddr);
    end
  end

  // Read data registered in the address phase; live counts, not reloads
  always_comb begin
    next_rdata = '0;
    case (addr_index(i_ahb.haddr))
      IDX_MODE:      next_rdata[7:0] = mode;
      IDX_PRESCALER: next_rdata[CNT_W-1:0] = pre_cnt;
      IDX_TIMER:     next_rdata[CNT_W-1:0] = main_cnt;
      IDX_SOURCE:    next_rdata[1:0] = source_sel;
      IDX_IRQ_STAT:  next_rdata[IRQ_W-1:0] = irq_stat;
      IDX_IRQ_MASK:  next_rdata[IRQ_W-1:0] = irq_mask;
      default:       next_rdata = '0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ahb.hreadyout <= 1'b1;
      o_ahb.hresp     <= 1'b0;
      o_ahb.hrdata    <= '0;
    end else begin
      o_ahb.hreadyout <= 1'b1;
      o_ahb.hresp     <= 1'b0;
      o_ahb.hrdata    <= rd_take ? next_rdata : '0;
    end
  end

  // Control registers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode <= MODE_RESET;
    end else if (wr_mode) begin
      mode <= wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      source_sel <= SOURCE_RESET;
      irq_mask   <= IRQ_RESET;
    end else if (dp_write) begin
      if (dp_index == IDX_SOURCE) begin
        source_sel <= wdata[1:0];
      end
      if (dp_index == IDX_IRQ_MASK) begin
        irq_mask <= wdata[IRQ_W-1:0];
      end
    end
  end

  // Only the all-zero mode select gives basic timer mode
  assign basic_mode = !mode[MODE_SEL_LOW0] && !mode[MODE_SEL_LOW1]
                      && !mode[MODE_SEL_UPPER];
  assign running    = mode[MODE_RUN] && basic_mode;

  // Count source generation
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ring_sync <= '0;
      ring_prev <= 1'b0;
    end else begin
      ring_sync <= {ring_sync[0], i_ring_osc_clock};
      ring_prev <= ring_sync[1];
    end
  end

  always_comb begin
    case (source_sel)
      SRC_DIV1: src_tick = 1'b1;
      SRC_DIV2: src_tick = div_cnt[0];
      SRC_DIV8: src_tick = (div_cnt == DIV8_LAST);
      SRC_RING: src_tick = ring_sync[1] && !ring_prev;
      default:  src_tick = 1'b0;
    endcase
  end

  assign pre_tick   = running && src_tick;
  assign pre_under  = pre_tick && (pre_phase == LOAD_IDLE) && (pre_cnt == '0);
  assign main_under = pre_under && (main_phase == LOAD_IDLE) && (main_cnt == '0);

  // Prescaler: reload register and counter
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_reload <= CNT_RESET;
      pre_cnt    <= CNT_RESET;
      pre_hold   <= CNT_RESET;
      pre_phase  <= LOAD_IDLE;
    end else if (wr_pre && !running) begin
      pre_reload <= wdata;
      pre_cnt    <= wdata;
      pre_phase  <= LOAD_IDLE;
    end else if (wr_pre) begin
      pre_hold  <= wdata;
      pre_phase <= LOAD_RELOAD;
    end else if (pre_tick) begin
      case (pre_phase)
        LOAD_RELOAD: begin
          pre_reload <= pre_hold;
          pre_phase  <= LOAD_COUNTER;
        end
        LOAD_COUNTER: begin
          pre_cnt   <= pre_reload;
          pre_phase <= LOAD_IDLE;
        end
        default: begin
          pre_cnt <= (pre_cnt == '0) ? pre_reload : pre_cnt - 8'h01;
        end
      endcase
    end
  end

  // Main counter, clocked by prescaler underflow
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      main_reload <= CNT_RESET;
      main_cnt    <= CNT_RESET;
      main_hold   <= CNT_RESET;
      main_phase  <= LOAD_IDLE;
    end else if (wr_main && !running) begin
      main_reload <= wdata;
      main_cnt    <= wdata;
      main_phase  <= LOAD_IDLE;
    end else if (wr_main) begin
      main_hold  <= wdata;
      main_phase <= LOAD_RELOAD;
    end else if (pre_under) begin
      case (main_phase)
        LOAD_RELOAD: begin
          main_reload <= main_hold;
          main_phase  <= LOAD_COUNTER;
        end
        LOAD_COUNTER: begin
          main_cnt   <= main_reload;
          main_phase <= LOAD_IDLE;
        end
        default: begin
          main_cnt <= (main_cnt == '0) ? main_reload : main_cnt - 8'h01;
        end
      endcase
    end
  end

  // External interrupt input only; no timer function on the pins
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_sync <= '0;
      ext_prev <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[0], i_ext_interrupt_input};
      ext_prev <= ext_active;
    end
  end

  // Polarity folded into the level, so a rewrite can look like an edge
  assign ext_active = ext_sync[1] ^ mode[MODE_POLARITY];
  assign ext_edge   = ext_active && !ext_prev && basic_mode;

  // Sticky status, cleared by a read, a new event wins
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat <= IRQ_RESET;
    end else begin
      irq_stat[IRQ_BIT_UNDER] <= main_under || (irq_stat[IRQ_BIT_UNDER] && !clr_stat);
      irq_stat[IRQ_BIT_EXT]   <= ext_edge || (irq_stat[IRQ_BIT_EXT] && !clr_stat);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat & irq_mask);
    end
  end

  // Checks
  a_under_sets_flag: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    main_under |=> irq_stat[IRQ_BIT_UNDER])
    else $error("Underflow did not set timer status");

  a_main_reloads: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    main_under && !wr_main |=> main_cnt == $past(main_reload))
    else $error("Main counter did not reload on underflow");

  a_pre_decrements: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    pre_tick && !wr_pre && pre_phase == LOAD_IDLE && pre_cnt != '0
    |=> pre_cnt == $past(pre_cnt) - 8'h01)
    else $error("Prescaler did not decrement on source tick");

  a_stop_holds: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !running && !wr_main && !wr_pre |=> $stable(main_cnt) && $stable(pre_cnt))
    else $error("Counter moved while halted");

  a_stopped_write: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    wr_main && !running ##1 !wr_main[*2]
    |-> main_cnt == $past(main_reload) && main_reload == $past(wdata, 2))
    else $error("Halted write did not load reload and counter");

  a_run_write_seq: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    pre_phase == LOAD_RELOAD && pre_tick && !wr_pre
    |=> pre_phase == LOAD_COUNTER && pre_reload == $past(pre_hold))
    else $error("Running write skipped reload stage");

  a_irq_follows: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    ##1 o_irq == |($past(irq_stat) & $past(irq_mask)))
    else $error("Interrupt output does not follow masked status");

  a_ext_edge_flag: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(ext_active) && basic_mode |=> irq_stat[IRQ_BIT_EXT])
    else $error("Selected edge did not set external status");

  a_mode_reset: assert property (
    @(posedge i_core_clk) $rose(i_rst_n) |-> mode == MODE_RESET && !running)
    else $error("Mode register not zero after reset");

  a_bus_ready: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    o_ahb.hreadyout && !o_ahb.hresp)
    else $error("Slave stalled or answered error");

  a_other_mode_halts: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (mode[MODE_SEL_LOW0] || mode[MODE_SEL_LOW1] || mode[MODE_SEL_UPPER])
    && !wr_main && !wr_pre
    |=> $stable(main_cnt) && $stable(pre_cnt))
    else $error("Counter moved outside basic timer mode");

  a_main_write_seq: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    main_phase == LOAD_COUNTER && pre_under && !wr_main
    |=> main_phase == LOAD_IDLE && main_cnt == $past(main_reload))
    else $error("Running write did not move reload into counter");

  a_status_clears: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    clr_stat && !main_under |=> !irq_stat[IRQ_BIT_UNDER])
    else $error("Status read did not clear timer flag");

endmodule : timer_x_basic

// ### tb_top.sv
// Self-checking bench for the basic timer block
`timescale 1ns/1ps
module tb_top;
  import timer_x_pkg::*;
  logic                 i_core_clk;
  logic                 i_rst_n;
  logic                 hsel;
  logic [31:0]          haddr;
  logic [1:0]           htrans;
  logic                 hwrite;
  logic [2:0]           hsize;
  logic [31:0]          hwdata;
  logic                 ring = 1'b0;
  logic                 ext;
  logic                 o_irq;
  ahb_in_s              bus_i;
  ahb_out_s             bus_o;
  int                   error_cnt;
  int                   n_compared;
  int                   cyc = 0;
  int                   ring_cnt = 0;
  logic [31:0]          v;
  logic [7:0]           n;
  logic [7:0]           m;
  logic [7:0]           pm;
  int                   t1;
  int                   t2;
  int                   f;
  logic [1:0]           srcs [4] = '{SRC_RING, SRC_DIV8, SRC_DIV2, SRC_DIV1};
  int                   fac [4] = '{10, 8, 2, 1};

  assign bus_i = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
                   hsize: hsize, hready: bus_o.hreadyout, hwdata: hwdata};

  timer_x_basic u_timer_x_basic (
    .i_core_clk           (i_core_clk),
    .i_rst_n              (i_rst_n),
    .i_ahb                (bus_i),
    .o_ahb                (bus_o),
    .i_ring_osc_clock     (ring),
    .i_ext_interrupt_input(ext),
    .o_irq                (o_irq)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  // Ring source rises once every ten core cycles
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    ring_cnt <= (ring_cnt == 9) ? 0 : ring_cnt + 1;
    ring <= (ring_cnt < 5);
  end

  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic xfer(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge i_core_clk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {20'h0, idx, 2'b00};
    hwrite <= wr;
    // Ready and data are read before the edge's own updates land
    do begin
      @(posedge i_core_clk);
      k++;
    end while (bus_o.hreadyout !== 1'b1 && k < 100);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge i_core_clk);
      k++;
    end while (bus_o.hreadyout !== 1'b1 && k < 200);
    rd = bus_o.hrdata;
    if (bus_o.hreadyout !== 1'b1) begin
      error_cnt++;
      $display("mismatch hready expected 1 seen %b", bus_o.hreadyout);
    end
  endtask : xfer

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    xfer(1'b1, idx, {24'h0, d}, rd);
  endtask : wr

  task automatic rdc(input string name, input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    xfer(1'b0, idx, 32'h0, rd);
    chk(name, exp, rd);
  endtask : rdc

  task automatic wait_irq(output int t);
    int k;
    for (k = 0; k < 3000; k++) begin
      @(negedge i_core_clk);
      if (o_irq === 1'b1) break;
    end
    if (k == 3000) begin
      error_cnt++;
      $display("mismatch irq expected 1 seen %b", o_irq);
    end
    t = cyc;
  endtask : wait_irq

  // Polarity rewrite in basic mode turns into an edge when the level flips high
  function automatic logic pol_edge(input logic [7:0] old_mode, input logic [7:0] new_mode);
    pol_edge = !old_mode[MODE_POLARITY] && new_mode[MODE_POLARITY]
               && !new_mode[MODE_SEL_LOW0] && !new_mode[MODE_SEL_LOW1]
               && !new_mode[MODE_SEL_UPPER];
  endfunction : pol_edge

  task automatic cycles(input int k);
    repeat (k) @(posedge i_core_clk);
  endtask : cycles

  initial begin
    #(25 * 60000);
    error_cnt++;
    results();
  end

  initial begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
    ext = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    i_rst_n = 1'b0;
    void'($urandom(32'h0147780f));
    cycles(3);
    i_rst_n <= 1'b1;
    rdc("mode", IDX_MODE, 32'h00);
    rdc("prescaler", IDX_PRESCALER, 32'hff);
    rdc("timer", IDX_TIMER, 32'hff);
    rdc("source", IDX_SOURCE, 32'h0);
    rdc("status", IDX_IRQ_STAT, 32'h0);
    rdc("mask", IDX_IRQ_MASK, 32'h0);
    rdc("unmapped", 10'h3ff, 32'h0);
    $display("test reset done");
    pm = 8'h00;
    repeat (4) begin
      v = $urandom & 32'hf7;
      wr(IDX_MODE, v[7:0]);
      rdc("mode bits", IDX_MODE, v);
      rdc("polarity flag", IDX_IRQ_STAT, {30'h0, pol_edge(pm, v[7:0]), 1'b0});
      pm = v[7:0];
    end
    wr(IDX_MODE, 8'h00);
    $display("test mode bits done");
    for (int i = 0; i < 4; i++) begin
      n = 8'($urandom_range(1, 7));
      m = 8'($urandom_range(1, 7));
      f = fac[i];
      wr(IDX_MODE, 8'h00);
      wr(IDX_SOURCE, {6'h0, srcs[i]});
      wr(IDX_PRESCALER, n);
      wr(IDX_TIMER, m);
      rdc("halted prescaler", IDX_PRESCALER, {24'h0, n});
      rdc("halted timer", IDX_TIMER, {24'h0, m});
      rdc("status clear", IDX_IRQ_STAT, (i == 0) ? 32'h0 : 32'h1);
      wr(IDX_IRQ_MASK, 8'h01);
      wr(IDX_MODE, 8'h08);
      wait_irq(t1);
      rdc("underflow flag", IDX_IRQ_STAT, 32'h1);
      wait_irq(t2);
      chk("period", f * (n + 1) * (m + 1), t2 - t1);
      $display("test source %0d done", i);
    end
    // Still running on the undivided source
    wr(IDX_PRESCALER, n);
    m = 8'($urandom_range(2, 6));
    wr(IDX_TIMER, m);
    rdc("status", IDX_IRQ_STAT, 32'h1);
    wait_irq(t1);
    rdc("status", IDX_IRQ_STAT, 32'h1);
    wait_irq(t1);
    rdc("status", IDX_IRQ_STAT, 32'h1);
    wait_irq(t2);
    chk("running reload period", (n + 1) * (m + 1), t2 - t1);
    wr(IDX_IRQ_MASK, 8'h00);
    cycles(100);
    chk("masked irq", 32'h0, {31'h0, o_irq});
    rdc("masked status", IDX_IRQ_STAT, 32'h1);
    $display("test running write and mask done");
    wr(IDX_MODE, 8'h00);
    // Drop any flag left by the free-running period after stopping
    xfer(1'b0, IDX_IRQ_STAT, 32'h0, v);
    wr(IDX_PRESCALER, 8'h07);
    wr(IDX_TIMER, 8'h07);
    wr(IDX_MODE, 8'h08);
    xfer(1'b0, IDX_PRESCALER, 32'h0, v);
    rdc("live count moves", IDX_PRESCALER, (v + 32'h5) & 32'h7);
    wr(IDX_MODE, 8'h00);
    xfer(1'b0, IDX_TIMER, 32'h0, v);
    cycles(40);
    rdc("halted timer holds", IDX_TIMER, v);
    wr(IDX_MODE, 8'h28);
    cycles(20);
    rdc("other mode halts", IDX_TIMER, v);
    wr(IDX_MODE, 8'h00);
    $display("test live count done");
    rdc("status", IDX_IRQ_STAT, 32'h0);
    wr(IDX_IRQ_MASK, 8'h02);
    ext <= 1'b1;
    cycles(8);
    chk("ext irq", 32'h1, {31'h0, o_irq});
    rdc("ext rising", IDX_IRQ_STAT, 32'h2);
    wr(IDX_MODE, 8'h04);
    cycles(8);
    rdc("polarity rewrite", IDX_IRQ_STAT, 32'h0);
    ext <= 1'b0;
    cycles(8);
    rdc("ext falling", IDX_IRQ_STAT, 32'h2);
    ext <= 1'b1;
    cycles(8);
    rdc("ext rising ignored", IDX_IRQ_STAT, 32'h0);
    $display("test external edge done");
    results();
  end
endmodule : tb_top
